// *** core/cpu_regs_pkg.sv ***
// constants and types shared by the core register set
// Notes on behaviour
// - sixteen 32-bit general registers, data and address
// - register zero doubles as index register
// - register fifteen is the stack pointer
// - vector base holds exception table base
// - global base holds relative addressing base
// - reserved status bits read zero; software writes zero
// - divide flags q and m are read/write
// - interrupt mask level resets to all ones
// - saturation flag used by multiply-accumulate
// - true flag records outcome, steers branches
// - true flag captures carry, borrow, overflow
// - high and low accumulator take multiply results
// - return address register holds subroutine return
// - program counter reads four bytes ahead
// - reset loads pc, sp; clears vector base
// - byte and word loads sign-extend to 32 bits
// - misaligned word or longword raises address error
// - endianness taken from mode pin at reset
// - arithmetic 8-bit immediates sign-extend
// - logical 8-bit immediates zero-extend
// - wider immediates come from pc-relative table
package cpu_regs_pkg;

   // ---------------------------------------------------------------
   // register counts and special indices
   // ---------------------------------------------------------------
   localparam int unsigned GPR_COUNT = 16;
   localparam int unsigned SYS_COUNT = 5;
   localparam logic [3:0] INDEX_REG = 4'h0;
   localparam logic [3:0] SP_INDEX = 4'hf;

   // ---------------------------------------------------------------
   // wishbone byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_GPR = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h40;
   localparam logic [7:0] OFF_SYS = 8'h44;
   localparam logic [7:0] OFF_PC = 8'h58;
   localparam logic [7:0] OFF_MODE = 8'h5c;

   // index of each register inside the system bank
   localparam logic [2:0] SYS_GBR = 3'h0;
   localparam logic [2:0] SYS_VBR = 3'h1;
   localparam logic [2:0] SYS_ACCUMULATOR_HIGH = 3'h2;
   localparam logic [2:0] SYS_ACCUMULATOR_LOW = 3'h3;
   localparam logic [2:0] SYS_PR = 3'h4;

   // ---------------------------------------------------------------
   // status word layout and reset values
   // ---------------------------------------------------------------
   localparam int unsigned SW_T = 0;
   localparam int unsigned SW_S = 1;
   localparam int unsigned SW_MASK_LSB = 4;
   localparam int unsigned SW_Q = 8;
   localparam int unsigned SW_M = 9;
   localparam logic [31:0] SW_LIVE = 32'h0000_03f3;
   localparam logic [31:0] SW_RESET = 32'h0000_00f0;
   localparam logic [3:0] MASK_RESET = 4'hf;
   localparam logic [31:0] VBR_RESET = 32'h0000_0000;

   // ---------------------------------------------------------------
   // vector table entries and address steps
   // ---------------------------------------------------------------
   localparam logic [31:0] VEC_PC_OFF = 32'h0000_0000;
   localparam logic [31:0] VEC_SP_OFF = 32'h0000_0004;
   localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
   localparam logic [31:0] INSN_BYTES = 32'h0000_0002;
   localparam logic [31:0] SP_STEP = 32'h0000_0004;

   // access size of a load or a memory access
   typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG} size_type;
   // reset-time vector fetch sequence
   typedef enum logic [1:0] {BOOT_PC, BOOT_SP, BOOT_RUN} boot_type;

endpackage : cpu_regs_pkg

// *** core/fmt_if.sv ***
// operand formatting signals between register set and formatter
`timescale 1ns/10ps
interface fmt_if;
   import cpu_regs_pkg::*;
   logic [7:0] imm8;      // immediate field of the instruction
   logic imm_sign;        // high for arithmetic use, low for logical
   logic [31:0] ld_word;  // raw bus word of a load
   size_type ld_size;     // size of the load being written back
   logic [31:0] addr;     // address of the memory access
   size_type acc_size;    // size of the memory access
   logic big;             // big-endian ordering selected
   logic [31:0] pc;       // program counter as seen by execution
   logic [7:0] disp;      // pc-relative displacement
   logic pc_long;         // longword table entry, else word
   logic [31:0] imm_ext;  // extended immediate
   logic [31:0] ld_ext;   // extended load value
   logic [31:0] pcrel;    // table entry address
   logic misaligned;      // access breaks its size boundary
   modport user (output imm8, imm_sign, ld_word, ld_size, addr, acc_size, big, pc, disp,
      pc_long, input imm_ext, ld_ext, pcrel, misaligned);
   modport fmt (input imm8, imm_sign, ld_word, ld_size, addr, acc_size, big, pc, disp,
      pc_long, output imm_ext, ld_ext, pcrel, misaligned);
endinterface : fmt_if

// *** core/operand_formatter.sv ***
// sign/zero extension, lane selection and alignment checks
`timescale 1ns/10ps
module operand_formatter
   import cpu_regs_pkg::*;
(
   fmt_if.fmt f
);

   // ---------------------------------------------------------------
   // load lane selection; bus lane n carries byte address n
   // ---------------------------------------------------------------
   wire [31:0] lane_shift = f.ld_word >> {f.addr[1:0], 3'b000};
   wire [7:0] ld_byte = lane_shift[7:0];
   wire [15:0] half_raw = f.addr[1] ? f.ld_word[31:16] : f.ld_word[15:0];
   // big-endian puts the lower address in the upper half
   wire [15:0] ld_half = f.big ? {half_raw[7:0], half_raw[15:8]} : half_raw;
   wire [31:0] ld_long = f.big ? {f.ld_word[7:0], f.ld_word[15:8], f.ld_word[23:16],
      f.ld_word[31:24]} : f.ld_word;

   // narrow loads always widen with their sign
   assign f.ld_ext = (f.ld_size == SIZE_BYTE) ? {{24{ld_byte[7]}}, ld_byte} :
                     (f.ld_size == SIZE_WORD) ? {{16{ld_half[15]}}, ld_half} : ld_long;

   // arithmetic immediates widen with sign, logical with zeros
   assign f.imm_ext = f.imm_sign ? {{24{f.imm8[7]}}, f.imm8} : {24'h000000, f.imm8};

   // bytes go anywhere; words on even, longwords on 4n
   assign f.misaligned = ((f.acc_size == SIZE_WORD) && f.addr[0]) ||
                         ((f.acc_size == SIZE_LONG) && (f.addr[1:0] != 2'b00));

   // wide constants live in a table reached from the pc
   assign f.pcrel = f.pc_long ? ({f.pc[31:2], 2'b00} + {22'h000000, f.disp, 2'b00}) :
                                (f.pc + {23'h000000, f.disp, 1'b0});

endmodule : operand_formatter

// *** core/cpu_register_set.sv ***
// programmer-visible register set of the core with wishbone access
`timescale 1ns/10ps
module cpu_register_set
   import cpu_regs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // reset vector fetch
   output logic vec_req_o,
   output logic [31:0] vec_addr_o,
   input wire logic vec_ack_i,
   input wire logic [31:0] vec_data_i,
   output logic ready_o,
   // endianness strap
   input wire logic mode_pin_i,
   output logic big_endian_o,
   // general register write-back
   input wire logic gr_we_i,
   input wire logic [3:0] gr_wsel_i,
   input wire size_type gr_wsize_i,
   input wire logic [31:0] gr_wdata_i,
   // general register reads
   input wire logic [3:0] rd_a_sel_i,
   input wire logic [3:0] rd_b_sel_i,
   output logic [31:0] rd_a_o,
   output logic [31:0] rd_b_o,
   output logic [31:0] index_o,
   output logic [31:0] stack_pointer_o,
   // exception stack traffic
   input wire logic sp_push_i,
   input wire logic sp_pop_i,
   // status word updates
   input wire logic sw_we_i,
   input wire logic [31:0] sw_wdata_i,
   input wire logic t_we_i,
   input wire logic t_i,
   input wire logic div_we_i,
   input wire logic div_q_i,
   input wire logic div_m_i,
   input wire logic s_we_i,
   input wire logic s_i,
   output logic [31:0] status_word_o,
   output logic [3:0] mask_level_o,
   // conditional branch
   input wire logic br_valid_i,
   input wire logic br_if_true_i,
   output logic branch_take_o,
   // control and system registers
   input wire logic sys_we_i,
   input wire logic [2:0] sys_sel_i,
   input wire logic [31:0] sys_wdata_i,
   input wire logic mac_we_i,
   input wire logic [31:0] mac_hi_i,
   input wire logic [31:0] mac_lo_i,
   output logic [31:0] global_base_o,
   output logic [31:0] vector_base_o,
   output logic [31:0] acc_high_o,
   output logic [31:0] acc_low_o,
   output logic [31:0] return_address_o,
   // program counter
   input wire logic pc_step_i,
   input wire logic pc_load_i,
   input wire logic [31:0] pc_target_i,
   output logic [31:0] pc_o,
   // operand formatting
   input wire logic [7:0] imm8_i,
   input wire logic imm_sign_i,
   output logic [31:0] imm_ext_o,
   input wire logic [7:0] disp_i,
   input wire logic pc_long_i,
   output logic [31:0] pcrel_addr_o,
   input wire logic acc_valid_i,
   input wire logic [31:0] acc_addr_i,
   input wire size_type acc_size_i,
   output logic addr_err_o
);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [31:0] gpr [GPR_COUNT];  // general registers
   logic [31:0] sys [SYS_COUNT];  // control and system bank
   logic [31:0] status_word;      // status word, reserved bits held zero
   logic [31:0] pc;               // pc as execution sees it
   boot_type state;               // reset vector sequence
   logic strap_done;              // mode pin already sampled

   // merge the enabled byte lanes of a bus write into a register
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   // ---------------------------------------------------------------
   // operand formatter
   // ---------------------------------------------------------------
   fmt_if fmt ();

   assign fmt.imm8 = imm8_i;
   assign fmt.imm_sign = imm_sign_i;
   assign fmt.ld_word = gr_wdata_i;
   assign fmt.ld_size = gr_wsize_i;
   assign fmt.addr = acc_addr_i;
   assign fmt.acc_size = acc_size_i;
   assign fmt.big = big_endian_o;
   assign fmt.pc = pc;
   assign fmt.disp = disp_i;
   assign fmt.pc_long = pc_long_i;

   operand_formatter u_formatter (
      .f(fmt.fmt)
   );

   // ---------------------------------------------------------------
   // wishbone decode
   // ---------------------------------------------------------------
   // one request per handshake; ack low gates the second cycle
   wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire bus_wr = bus_req && wb_we_i;
   wire hit_gpr = (wb_adr_i < OFF_STATUS);
   wire hit_sw = (wb_adr_i[7:2] == OFF_STATUS[7:2]);
   wire hit_sys = (wb_adr_i >= OFF_SYS) && (wb_adr_i < OFF_PC);
   wire hit_pc = (wb_adr_i[7:2] == OFF_PC[7:2]);
   wire hit_mode = (wb_adr_i[7:2] == OFF_MODE[7:2]);
   wire [7:0] sys_off = wb_adr_i - OFF_SYS;
   wire [2:0] sys_idx = sys_off[4:2];
   wire [3:0] gpr_idx = wb_adr_i[5:2];

   // unmapped words read zero and swallow writes
   wire [31:0] rd_mux = hit_gpr ? gpr[gpr_idx] :
                        hit_sw ? status_word :
                        hit_sys ? sys[sys_idx] :
                        hit_pc ? pc :
                        hit_mode ? {31'h00000000, big_endian_o} : 32'h00000000;

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req) begin
            wb_dat_o <= rd_mux;
         end
      end
   end

   // ---------------------------------------------------------------
   // reset vector fetch
   // ---------------------------------------------------------------
   wire boot_pc_take = (state == BOOT_PC) && vec_ack_i;
   wire boot_sp_take = (state == BOOT_SP) && vec_ack_i;

   // pc entry first, stack pointer entry second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= BOOT_PC;
      end else begin
         unique case (state)
            BOOT_PC: if (vec_ack_i) state <= BOOT_SP;
            BOOT_SP: if (vec_ack_i) state <= BOOT_RUN;
            BOOT_RUN: state <= BOOT_RUN;
         endcase
      end
   end

   // request stays up until the second entry is
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vec_req_o <= 1'b1;
         vec_addr_o <= VBR_RESET + VEC_PC_OFF;
         ready_o <= 1'b0;
      end else if (boot_pc_take) begin
         vec_addr_o <= sys[SYS_VBR] + VEC_SP_OFF;
      end else if (boot_sp_take) begin
         vec_req_o <= 1'b0;
         ready_o <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // endianness strap
   // ---------------------------------------------------------------
   // the pin is taken on the first edge after release, then frozen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_done <= 1'b0;
         big_endian_o <= 1'b0;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         big_endian_o <= mode_pin_i;
      end
   end

   // ---------------------------------------------------------------
   // general registers
   // ---------------------------------------------------------------
   // exception entry pushes, return pops, a longword each
   wire sp_load = boot_sp_take || sp_push_i || sp_pop_i;
   wire [31:0] sp_next = boot_sp_take ? vec_data_i :
                         sp_push_i ? (gpr[SP_INDEX] - SP_STEP) : (gpr[SP_INDEX] + SP_STEP);

   // write-back beats stack traffic, which beats the bus
   for (genvar g = 0; g < GPR_COUNT; g++) begin : g_gpr
      wire dp_hit = gr_we_i && (gr_wsel_i == 4'(g));
      wire sp_hit = (4'(g) == SP_INDEX) && sp_load;
      wire bus_hit = bus_wr && hit_gpr && (gpr_idx == 4'(g));
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            gpr[g] <= 32'h00000000;
         end else if (dp_hit) begin
            gpr[g] <= fmt.ld_ext;
         end else if (sp_hit) begin
            gpr[g] <= sp_next;
         end else if (bus_hit) begin
            gpr[g] <= merge_bytes(gpr[g], wb_dat_i, wb_sel_i);
         end
      end
   end

   // registered read ports, one cycle behind the select
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_a_o <= 32'h00000000;
         rd_b_o <= 32'h00000000;
      end else begin
         rd_a_o <= gpr[rd_a_sel_i];
         rd_b_o <= gpr[rd_b_sel_i];
      end
   end

   assign index_o = gpr[INDEX_REG];
   assign stack_pointer_o = gpr[SP_INDEX];

   // ---------------------------------------------------------------
   // status word
   // ---------------------------------------------------------------
   wire sw_bus_hit = bus_wr && hit_sw;
   wire [31:0] sw_base = sw_we_i ? sw_wdata_i :
                         sw_bus_hit ? merge_bytes(status_word, wb_dat_i, wb_sel_i) : status_word;
   // instruction flag updates override a same-cycle bus write
   wire [31:0] flag_mask = ({31'h0, t_we_i} << SW_T) | ({31'h0, s_we_i} << SW_S) |
                           ({31'h0, div_we_i} << SW_Q) | ({31'h0, div_we_i} << SW_M);
   wire [31:0] flag_val = ({31'h0, t_i} << SW_T) | ({31'h0, s_i} << SW_S) |
                          ({31'h0, div_q_i} << SW_Q) | ({31'h0, div_m_i} << SW_M);
   // reserved positions are masked off, whatever gets written
   wire [31:0] next_status = ((sw_base & ~flag_mask) | flag_val) & SW_LIVE;

   // t takes outcomes and carries, q/m divide, s multiply-accumulate
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_word <= SW_RESET;
      end else begin
         status_word <= next_status;
      end
   end

   assign status_word_o = status_word;
   assign mask_level_o = status_word[SW_MASK_LSB +: 4];

   // branch decision sampled from the stored flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         branch_take_o <= 1'b0;
      end else begin
         branch_take_o <= br_valid_i && (status_word[SW_T] == br_if_true_i);
      end
   end

   // ---------------------------------------------------------------
   // control and system bank
   // ---------------------------------------------------------------
   for (genvar g = 0; g < SYS_COUNT; g++) begin : g_sys
      wire is_accumulator_high = (3'(g) == SYS_ACCUMULATOR_HIGH);
      wire mac_hit = mac_we_i && (is_accumulator_high || (3'(g) == SYS_ACCUMULATOR_LOW));
      wire dp_hit = sys_we_i && (sys_sel_i == 3'(g));
      wire bus_hit = bus_wr && hit_sys && (sys_idx == 3'(g));
      // multiplier writes both halves together
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            sys[g] <= (3'(g) == SYS_VBR) ? VBR_RESET : 32'h00000000;
         end else if (mac_hit) begin
            sys[g] <= is_accumulator_high ? mac_hi_i : mac_lo_i;
         end else if (dp_hit) begin
            sys[g] <= sys_wdata_i;
         end else if (bus_hit) begin
            sys[g] <= merge_bytes(sys[g], wb_dat_i, wb_sel_i);
         end
      end
   end

   assign global_base_o = sys[SYS_GBR];
   assign vector_base_o = sys[SYS_VBR];
   assign acc_high_o = sys[SYS_ACCUMULATOR_HIGH];
   assign acc_low_o = sys[SYS_ACCUMULATOR_LOW];
   assign return_address_o = sys[SYS_PR];

   // ---------------------------------------------------------------
   // program counter
   // ---------------------------------------------------------------
   // held four bytes past the executing instruction
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc <= 32'h00000000;
      end else if (boot_pc_take) begin
         pc <= vec_data_i + PC_AHEAD;
      end else if (state == BOOT_RUN) begin
         if (pc_load_i) begin
            pc <= pc_target_i + PC_AHEAD;
         end else if (pc_step_i) begin
            pc <= pc + INSN_BYTES;
         end
      end
   end

   assign pc_o = pc;

   // ---------------------------------------------------------------
   // registered formatter results
   // ---------------------------------------------------------------
   // a misaligned access's data is not trusted downstream
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         imm_ext_o <= 32'h00000000;
         pcrel_addr_o <= 32'h00000000;
         addr_err_o <= 1'b0;
      end else begin
         imm_ext_o <= fmt.imm_ext;
         pcrel_addr_o <= fmt.pcrel;
         addr_err_o <= acc_valid_i && fmt.misaligned;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_RSV_ZERO: assert property ((status_word & ~SW_LIVE) == 32'h0)
      else $error("reserved status bits not zero");
   AST_MASK_RESET: assert property ($past(rst_i) |-> mask_level_o == MASK_RESET)
      else $error("mask level not all ones after reset");
   AST_VBR_RESET: assert property ($past(rst_i) |-> vector_base_o == VBR_RESET)
      else $error("vector base not cleared by reset");
   AST_SP_BOOT: assert property (boot_sp_take && !gr_we_i |=>
      stack_pointer_o == $past(vec_data_i) && ready_o)
      else $error("stack pointer not loaded from vector");
   AST_PC_STEP: assert property (state == BOOT_RUN && pc_step_i && !pc_load_i |=>
      pc_o == $past(pc_o) + INSN_BYTES)
      else $error("pc did not advance one instruction");
   AST_ALIGN: assert property (acc_valid_i && acc_size_i == SIZE_LONG &&
      acc_addr_i[1:0] != 2'b00 |=> addr_err_o)
      else $error("misaligned longword not flagged");
   AST_IMM_ZERO: assert property (!imm_sign_i |=> imm_ext_o[31:8] == 24'h000000)
      else $error("logical immediate not zero-extended");
   AST_IMM_SIGN: assert property (imm_sign_i && imm8_i[7] |=>
      imm_ext_o[31:8] == 24'hffffff)
      else $error("arithmetic immediate not sign-extended");
   AST_T_UPDATE: assert property (t_we_i |=> status_word_o[SW_T] == $past(t_i))
      else $error("flag did not take the result");
   AST_BRANCH: assert property (br_valid_i && status_word[SW_T] == br_if_true_i |=>
      branch_take_o)
      else $error("branch not taken on matching flag");
   AST_LOAD_SEXT: assert property (gr_we_i && gr_wsel_i == INDEX_REG &&
      gr_wsize_i == SIZE_BYTE |=> index_o[31:7] == '0 || index_o[31:7] == '1)
      else $error("byte load not sign-extended");
   AST_WB_ACK: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("wishbone ack not a single cycle");

   COV_BOOT_DONE: cover property (boot_sp_take ##1 ready_o);
   COV_SW_BUS_WRITE: cover property (sw_bus_hit);
   COV_MISALIGNED: cover property (addr_err_o);
   COV_BRANCH_TAKEN: cover property (branch_take_o);

endmodule : cpu_register_set

// *** tb/vec_mem.sv ***
// boot vector memory standing in for the core's fetch side
`timescale 1ns/10ps
module vec_mem #(
   parameter logic [31:0] PC_WORD = 32'h0000_1000,
   parameter logic [31:0] SP_WORD = 32'h0000_8000
) (
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   output logic ack_o,
   output logic [31:0] data_o
);
   logic slow = 1'b0; // alternates prompt and late answers
   logic go;          // answer this cycle
   assign go = req_i & slow & ~ack_o;
   initial {ack_o, data_o} = 33'h0;
   // pc entry at offset 0, sp at offset 4; idle data scrambles, never holds
   always @(posedge clk_i) begin
      slow <= ~slow;
      ack_o <= go;
      data_o <= go ? (addr_i[2] ? SP_WORD : PC_WORD) : ~data_o;
   end
endmodule : vec_mem

// *** tb/tb_top.sv ***
// random and corner-case bench for the core register set
`timescale 1ns/10ps
module tb_top;
   import cpu_regs_pkg::*;
   // signals carry the port names so that .* ties them up
   logic clk_i = 1'b0, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, vec_req_o, vec_ack_i;
   logic ready_o, mode_pin_i, big_endian_o, gr_we_i, sp_push_i, sp_pop_i, sw_we_i, t_we_i, t_i;
   logic div_we_i, div_q_i, div_m_i, s_we_i, s_i, br_valid_i, br_if_true_i, branch_take_o;
   logic sys_we_i, mac_we_i, pc_step_i, pc_load_i, imm_sign_i, pc_long_i, acc_valid_i, addr_err_o;
   logic [2:0] sys_sel_i;
   logic [3:0] wb_sel_i, gr_wsel_i, rd_a_sel_i, rd_b_sel_i, mask_level_o;
   logic [7:0] wb_adr_i, imm8_i, disp_i;
   size_type gr_wsize_i, acc_size_i;
   logic [31:0] wb_dat_i, wb_dat_o, vec_addr_o, vec_data_i, gr_wdata_i, rd_a_o, rd_b_o, index_o;
   logic [31:0] stack_pointer_o, sw_wdata_i, status_word_o, sys_wdata_i, mac_hi_i, mac_lo_i;
   logic [31:0] global_base_o, vector_base_o, acc_high_o, acc_low_o, return_address_o, e, p;
   logic [31:0] w [22]; // expected word of each general, status and system register
   logic [31:0] pc_target_i, pc_o, imm_ext_o, pcrel_addr_o, acc_addr_i;
   int n_errors = 0, num_checks = 0, seed = 88;
   cpu_register_set dut (.*);
   vec_mem far_end (.clk_i(clk_i), .req_i(vec_req_o), .addr_i(vec_addr_o), .ack_o(vec_ack_i),
      .data_o(vec_data_i));
   initial forever #25 clk_i = ~clk_i; // 20 MHz
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   task chk(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x) begin
         n_errors++;
         $display("MISMATCH %0t got %h want %h", $time, g, x);
      end
   endtask : chk
   // one classic cycle; held until ack is sampled, then one idle cycle
   task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
      int k;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hf, v};
      for (k = 0; k < 9 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
      chk(wb_ack_o, 1'b1); // a missing answer counts as a mismatch
      if (wb_ack_o !== 1'b1) end_sim;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge clk_i);
   endtask : wb
   function automatic logic [31:0] ext8(input logic [7:0] v, input logic s);
      return s ? {{24{v[7]}}, v} : {24'h00_0000, v};
   endfunction : ext8
   // wait for the vector fetch to finish, then check the reset picture
   task boot;
      for (int k = 0; k < 40 && ready_o !== 1'b1; k++) @(posedge clk_i);
      chk(ready_o, 1'b1);
      if (ready_o !== 1'b1) end_sim;
      chk(pc_o, far_end.PC_WORD + 32'h0000_0004);
      chk(stack_pointer_o, far_end.SP_WORD);
      chk(vector_base_o, 32'h0000_0000);
      chk(mask_level_o, 4'hf);
      chk(big_endian_o, mode_pin_i);
   endtask : boot
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, mode_pin_i, gr_we_i} = '0;
      {gr_wsel_i, gr_wdata_i, rd_a_sel_i, rd_b_sel_i, sp_push_i, sp_pop_i, sw_we_i} = '0;
      sw_wdata_i = '0;
      {t_we_i, t_i, div_we_i, div_q_i, div_m_i, s_we_i, s_i, br_valid_i, br_if_true_i} = '0;
      {sys_we_i, sys_sel_i, sys_wdata_i, mac_we_i, mac_hi_i, mac_lo_i, pc_step_i, pc_load_i} = '0;
      {pc_target_i, imm8_i, imm_sign_i, disp_i, pc_long_i, acc_valid_i, acc_addr_i} = '0;
      gr_wsize_i = SIZE_LONG;
      acc_size_i = SIZE_BYTE;
      rst_i = 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      boot;
      // every general, status and system word written and read back; status keeps only its live bits
      for (int r = 0; r < 22; r++) begin
         e = $random(seed);
         w[r] = (r == 16) ? (e & 32'h0000_03f3) : e;
         wb(1'b1, 8'(r * 4), e);
         wb(1'b0, 8'(r * 4), 32'h0);
         chk(wb_dat_o, w[r]);
      end
      // the pc word ignores bus writes
      wb(1'b1, 8'h58, e);
      wb(1'b0, 8'h58, 32'h0);
      chk(wb_dat_o, far_end.PC_WORD + 32'h0000_0004);
      sp_push_i <= 1'b1;
      @(posedge clk_i);
      sp_push_i <= 1'b0;
      @(posedge clk_i);
      chk(stack_pointer_o, w[15] - 32'h0000_0004);
      wb(1'b1, 8'h40, 32'hffff_ffff);
      wb(1'b0, 8'h40, 32'h0);
      chk(wb_dat_o, 32'h0000_03f3);
      // one cycle of the write-back, multiplier, system, pc-step and flag strobes, then a branch on the cleared flag
      e = $random(seed);
      {gr_we_i, gr_wsel_i, gr_wdata_i} <= {1'b1, 4'h0, e};
      {mac_we_i, mac_hi_i, mac_lo_i} <= {1'b1, e, ~e};
      {sys_we_i, sys_sel_i, sys_wdata_i, pc_step_i} <= {1'b1, 3'h4, e, 1'b1};
      {t_we_i, t_i, s_we_i, s_i, div_we_i, div_q_i, div_m_i} <= 7'b1010101;
      gr_wsize_i <= SIZE_BYTE;
      @(posedge clk_i);
      {gr_we_i, mac_we_i, sys_we_i, pc_step_i, t_we_i, s_we_i, div_we_i} <= '0;
      {br_valid_i, br_if_true_i, rd_a_sel_i, rd_b_sel_i} <= {2'b10, 4'h0, 4'hf};
      @(posedge clk_i);
      br_valid_i <= 1'b0;
      @(posedge clk_i);
      chk(branch_take_o, 1'b1);
      chk(status_word_o, 32'h0000_02f0);
      chk(rd_a_o, ext8(e[7:0], 1'b1));
      chk(rd_b_o, w[15] - 32'h0000_0004);
      chk(acc_high_o, e);
      chk(acc_low_o, ~e);
      chk(return_address_o, e);
      chk(pc_o, far_end.PC_WORD + 32'h0000_0006);
      p = far_end.PC_WORD + 32'h0000_0006;
      // every size against every low address pair, random immediates alongside
      for (int c = 0; c < 12; c++) begin
         e = $random(seed);
         {imm8_i, imm_sign_i, acc_valid_i, acc_addr_i} <= {e[7:0], e[8], 1'b1, e[31:2], 2'(c)};
         acc_size_i <= size_type'(c / 4);
         {disp_i, pc_long_i} <= e[16:8];
         repeat (2) @(posedge clk_i);
         chk(pcrel_addr_o, e[8] ? (p & 32'hffff_fffc) + {e[16:9], 2'b00} : p + {e[16:9], 1'b0});
         chk(imm_ext_o, ext8(e[7:0], e[8]));
         chk(addr_err_o, (c / 4 == 1 && c[0]) || (c / 4 == 2 && c[1:0] != 2'b00));
      end
      // mid-run reset with the strap set: big-endian longword loads come byte-reversed
      mode_pin_i <= 1'b1;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      boot;
      e = $random(seed);
      {gr_we_i, gr_wdata_i} <= {1'b1, e};
      gr_wsize_i <= SIZE_LONG;
      @(posedge clk_i);
      gr_we_i <= 1'b0;
      @(posedge clk_i);
      chk(index_o, {e[7:0], e[15:8], e[23:16], e[31:24]});
      end_sim;
   end
endmodule : tb_top
